// *** rtl/wdt_pkg.sv ***
/*
 * Shared constants of the watchdog control and status block: register
 * indices, field positions, reset values and timing counts.
 * Assumes a 50 MHz system clock and a slow watchdog oscillator on a pin.
 */
package wdt_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [1:0] IDX_CONTROL = 2'h0;
   localparam logic [1:0] IDX_STATUS = 2'h1;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
   // Field positions.
   localparam int PERIOD_LSB = 0;
   localparam int WINDOW_LSB = 4;
   localparam int LOCK_BIT = 7;
   localparam int SYNC_PENDING_BIT = 0;
   // Values after reset.
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Timeout codes and lengths in oscillator cycles.
   localparam logic [3:0] CODE_OFF = 4'h0;
   localparam logic [3:0] CODE_MAX = 4'hB;
   localparam int TIMEOUT_BASE_CYCLES = 8;
   localparam int CNT_W = 15;
   // Oscillator edges needed to carry a value into the watchdog domain.
   localparam logic [1:0] SYNC_TICKS = 2'h2;
   // Instructions (system cycles) that a timed-write unlock stays open.
   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
   typedef enum logic [2:0] {PH_OFF, PH_NORMAL, PH_FIRST, PH_CLOSED, PH_OPEN} phase_t;
endpackage

// *** rtl/osc_tick_sync.sv ***
/*
 * Two-flop synchroniser for the watchdog oscillator pin, followed by a
 * rising edge detector that yields one system-clock pulse per cycle.
 * Assumes the oscillator is far slower than ref_clk.
 */
module osc_tick_sync (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic osc_in,
   output logic tick
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         // A pin already high at release still counts as one edge, since meta_q and sync_q reset low.
         last_q <= 1'b1;
      end else begin
         meta_q <= osc_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign tick = sync_q & ~last_q;
endmodule // osc_tick_sync

// *** rtl/watchdog_control_status.sv ***
/*
 * Windowed watchdog: control and status registers on APB, timed-write
 * protection, configuration lock, synchronisation into the oscillator
 * domain and the timeout sequencer that raises a system reset.
 * Assumes unlock, restart and debug signals come from the CPU on ref_clk
 * and the oscillator arrives on a pin.
 */
// Register access over APB is this design's own decision.
// Summary of operation
// - Any non-zero period code enables the watchdog; zero turns it off.
// - Period codes 1 to 0xB give 8 to 8K oscillator cycles; others reserved.
// - In window mode the period code sets the open window length.
// - While locked, the timeout-select field ignores writes.
// - Outside debug mode, software can only write the lock bit to one.
// - The lock clears only by a write in debug mode, else until reset.
// - A non-zero period at end of boot sets the lock automatically.
// - Lock writes take effect only through the timed-write unlock.
// - Any accepted control write sets the sync pending flag during domain crossing.
// - Hardware clears sync pending when the crossing has finished.
// - Sync pending is read-only and outside the timed-write protection.
// - Non-zero closed-window code enables window mode; zero returns to normal.
// - Missing restart before timeout resets the system; restart starts afresh, except in the closed window, where it resets the system.
module watchdog_control_status (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_pin,
   input wire logic unlock_key,
   input wire logic restart_instr,
   input wire logic debug_mode,
   input wire logic boot_done,
   input wire logic [7:0] boot_config,
   output logic watchdog_enabled,
   output logic system_reset
);
   import wdt_pkg::*;

   typedef struct packed {
      logic booted;
      logic [7:0] control;
      logic [7:0] applied;
      logic lock;
      logic sync_pending;
      logic [1:0] sync_cnt;
      logic restart_pending;
      logic [1:0] restart_cnt;
      logic [2:0] unlock_cnt;
      phase_t phase;
      logic [CNT_W-1:0] cnt;
      logic [31:0] rdata;
      logic err;
      logic sys_reset;
      logic enabled;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic tick;
   logic access;
   logic wr_ctrl;
   logic wr_status;
   logic mapped;
   logic unlock_open;
   logic ctrl_accept;
   logic restart_apply;
   logic expire;

   osc_tick_sync u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .osc_in(osc_pin),
      .tick(tick)
   );

   // Timeout length in oscillator cycles; reserved codes use the longest.
   function automatic logic [CNT_W-1:0] timeout_len(input logic [3:0] code);
      logic [3:0] c;
      c = (code > CODE_MAX || code == CODE_OFF) ? CODE_MAX : code;
      timeout_len = CNT_W'(TIMEOUT_BASE_CYCLES) << (c - 4'h1);
   endfunction

   assign mapped = (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS);
   assign access = psel & penable;
   assign wr_ctrl = access & pwrite & (paddr == ADDR_CONTROL);
   assign wr_status = access & pwrite & (paddr == ADDR_STATUS);
   assign unlock_open = (s_q.unlock_cnt != 3'h0);
   // A control write changes nothing unless unlocked and not locked.
   assign ctrl_accept = wr_ctrl & unlock_open & ~s_q.lock;
   assign restart_apply = s_q.restart_pending & tick & (s_q.restart_cnt == SYNC_TICKS - 2'h1);
   assign expire = tick & (s_q.cnt + CNT_W'(1) >= timeout_len(
      (s_q.phase == PH_CLOSED) ? s_q.applied[WINDOW_LSB +: 4] : s_q.applied[PERIOD_LSB +: 4]));

   assign pready = 1'b1;
   assign prdata = s_q.rdata;
   assign pslverr = s_q.err;
   assign watchdog_enabled = s_q.enabled;
   assign system_reset = s_q.sys_reset;

   always_comb begin
      s_d = s_q;
      s_d.sys_reset = 1'b0;
      // The strap value is caught on the first clock after reset release.
      if (!s_q.booted) begin
         s_d.booted = 1'b1;
         s_d.control = boot_config;
         s_d.applied = boot_config;
      end
      // Unlock window: opened by the key, consumed by one protected write.
      if (unlock_key) begin
         s_d.unlock_cnt = UNLOCK_CYCLES;
      end else if (unlock_open) begin
         s_d.unlock_cnt = s_q.unlock_cnt - 3'h1;
      end
      if ((wr_ctrl | wr_status) & unlock_open & ~unlock_key) begin
         s_d.unlock_cnt = 3'h0;
      end
      // Read data is captured in the setup phase and held in the access phase.
      if (psel & ~penable) begin
         s_d.rdata = 32'h0000_0000;
         s_d.err = ~mapped;
         if (paddr == ADDR_CONTROL) begin
            s_d.rdata[7:0] = s_q.control;
         end else if (paddr == ADDR_STATUS) begin
            s_d.rdata[LOCK_BIT] = s_q.lock;
            s_d.rdata[SYNC_PENDING_BIT] = s_q.sync_pending;
         end
      end
      // Synchronisation of the control value into the oscillator domain.
      if (s_q.sync_pending && tick) begin
         if (s_q.sync_cnt == SYNC_TICKS - 2'h1) begin
            s_d.sync_pending = 1'b0;
            s_d.sync_cnt = 2'h0;
            s_d.applied = s_q.control;
         end else begin
            s_d.sync_cnt = s_q.sync_cnt + 2'h1;
         end
      end
      if (ctrl_accept) begin
         s_d.control = pwdata[7:0];
         s_d.sync_pending = 1'b1;
         s_d.sync_cnt = 2'h0;
      end
      // Lock: set by a protected write of one or at boot end, cleared only in debug.
      if (wr_status & unlock_open) begin
         if (pwdata[LOCK_BIT]) begin
            s_d.lock = 1'b1;
         end else if (debug_mode) begin
            s_d.lock = 1'b0;
         end
      end
      if (boot_done && s_q.control[PERIOD_LSB +: 4] != CODE_OFF) begin
         s_d.lock = 1'b1;
      end
      // Restart instruction crossing; a second one while pending is dropped.
      if (restart_instr && !s_q.restart_pending) begin
         s_d.restart_pending = 1'b1;
         s_d.restart_cnt = 2'h0;
      end else if (s_q.restart_pending && tick) begin
         if (restart_apply) begin
            s_d.restart_pending = 1'b0;
         end else begin
            s_d.restart_cnt = s_q.restart_cnt + 2'h1;
         end
      end
      // Timeout sequencer, counting oscillator edges.
      if (tick) begin
         s_d.cnt = s_q.cnt + CNT_W'(1);
      end
      case (s_q.phase)
         PH_OFF: begin
            s_d.cnt = '0;
            if (s_q.applied[PERIOD_LSB +: 4] != CODE_OFF) begin
               s_d.phase = (s_q.applied[WINDOW_LSB +: 4] != CODE_OFF) ? PH_FIRST : PH_NORMAL;
            end
         end
         PH_NORMAL, PH_FIRST, PH_OPEN: begin
            if (restart_apply) begin
               s_d.cnt = '0;
               s_d.phase = (s_q.applied[WINDOW_LSB +: 4] != CODE_OFF) ? PH_CLOSED : PH_NORMAL;
            end else if (expire) begin
               s_d.sys_reset = 1'b1;
               s_d.cnt = '0;
               s_d.phase = PH_OFF;
            end
         end
         PH_CLOSED: begin
            if (restart_apply) begin
               s_d.sys_reset = 1'b1;
               s_d.cnt = '0;
               s_d.phase = PH_OFF;
            end else if (expire) begin
               s_d.cnt = '0;
               s_d.phase = PH_OPEN;
            end
         end
         default: begin
            s_d.phase = PH_OFF;
         end
      endcase
      if (s_q.applied[PERIOD_LSB +: 4] == CODE_OFF) begin
         s_d.phase = PH_OFF;
         s_d.cnt = '0;
      end else if (s_q.phase != PH_OFF && s_q.applied[WINDOW_LSB +: 4] == CODE_OFF
                   && s_q.phase != PH_NORMAL && !s_d.sys_reset) begin
         s_d.phase = PH_NORMAL;
      end
      s_d.enabled = (s_d.applied[PERIOD_LSB +: 4] != CODE_OFF);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q.booted <= 1'b0;
         s_q.control <= CONTROL_RESET;
         s_q.applied <= CONTROL_RESET;
         s_q.lock <= STATUS_RESET[LOCK_BIT];
         s_q.sync_pending <= STATUS_RESET[SYNC_PENDING_BIT];
         s_q.sync_cnt <= 2'h0;
         s_q.restart_pending <= 1'b0;
         s_q.restart_cnt <= 2'h0;
         s_q.unlock_cnt <= 3'h0;
         s_q.phase <= PH_OFF;
         s_q.cnt <= '0;
         s_q.rdata <= 32'h0000_0000;
         s_q.err <= 1'b0;
         s_q.sys_reset <= 1'b0;
         s_q.enabled <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   sequence seq_ctrl_write;
      ctrl_accept;
   endsequence

   sequence seq_locked_write;
      s_q.booted && wr_ctrl && s_q.lock;
   endsequence

   sequence seq_lock_set_write;
      wr_status && unlock_open && pwdata[LOCK_BIT];
   endsequence

   sequence seq_restart_in_run;
      restart_apply && (s_q.phase != PH_OFF) && (s_q.phase != PH_CLOSED);
   endsequence

   sequence seq_timeout_due;
      expire && !restart_apply && (s_q.phase != PH_OFF) && (s_q.phase != PH_CLOSED);
   endsequence

   chk_period_off_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_q.applied[PERIOD_LSB +: 4] == CODE_OFF) |=> (s_q.phase == PH_OFF))
      else $error("watchdog active with period code zero");

   chk_locked_ctrl_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      seq_locked_write |=> $stable(s_q.control))
      else $error("control changed while locked");

   chk_lock_stays_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.lock && !debug_mode |=> s_q.lock)
      else $error("lock cleared outside debug");

   chk_lock_needs_unlock: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(s_q.lock) |-> $past(unlock_open) || $past(boot_done))
      else $error("lock set without timed write");

   chk_write_sets_pending: assert property (@(posedge ref_clk) disable iff (!rst_n)
      seq_ctrl_write |=> s_q.sync_pending ##0 (s_q.control == $past(pwdata[7:0])))
      else $error("accepted write did not start synchronisation");

   chk_pending_clears_tick: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(s_q.sync_pending) |-> $past(tick) && (s_q.applied == s_q.control))
      else $error("sync pending cleared without oscillator edge");

   chk_apply_after_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(s_q.booted) && $changed(s_q.applied) |-> $fell(s_q.sync_pending))
      else $error("control applied before synchronisation");

   chk_reset_on_expiry: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.sys_reset |-> $past(tick) ##1 !s_q.sys_reset)
      else $error("system reset not a single pulse after an oscillator edge");

   chk_closed_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_q.phase == PH_CLOSED) && restart_apply && (s_q.applied[PERIOD_LSB +: 4] != CODE_OFF) |=> s_q.sys_reset)
      else $error("restart in closed window did not reset");

   chk_lock_write_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      seq_lock_set_write |=> s_q.lock)
      else $error("protected write of one did not set lock");

   chk_lock_clear_debug: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(s_q.lock) |-> $past(debug_mode) && $past(wr_status) && $past(unlock_open))
      else $error("lock cleared without protected write in debug");

   chk_boot_auto_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
      boot_done && (s_q.control[PERIOD_LSB +: 4] != CODE_OFF) |=> s_q.lock)
      else $error("lock not set at end of boot");

   chk_ctrl_needs_unlock: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $past(s_q.booted) && $changed(s_q.control) |-> $past(unlock_open) && !$past(s_q.lock))
      else $error("control changed without timed write");

   chk_status_no_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_status && !s_q.sync_pending |=> !s_q.sync_pending)
      else $error("status write started synchronisation");

   chk_pending_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.sync_pending && !tick |=> s_q.sync_pending)
      else $error("sync pending cleared between oscillator edges");

   chk_pending_two_ticks: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(s_q.sync_pending) |-> $past(s_q.sync_cnt) == SYNC_TICKS - 2'h1)
      else $error("sync pending cleared before the second oscillator edge");

   chk_apply_waits: assert property (@(posedge ref_clk) disable iff (!rst_n)
      seq_ctrl_write ##0 !s_q.sync_pending |=> $stable(s_q.applied))
      else $error("control applied in the cycle of the write");

   chk_restart_rearms: assert property (@(posedge ref_clk) disable iff (!rst_n)
      seq_restart_in_run |=> (s_q.cnt == '0))
      else $error("restart did not begin a fresh period");

   chk_timeout_resets: assert property (@(posedge ref_clk) disable iff (!rst_n)
      seq_timeout_due ##0 (s_q.applied[PERIOD_LSB +: 4] != CODE_OFF) |=> s_q.sys_reset)
      else $error("timeout without system reset");

   chk_window_closes: assert property (@(posedge ref_clk) disable iff (!rst_n)
      seq_restart_in_run ##0 (s_q.applied[WINDOW_LSB +: 4] != CODE_OFF)
         ##0 (s_q.applied[PERIOD_LSB +: 4] != CODE_OFF) |=> (s_q.phase == PH_CLOSED))
      else $error("restart with window code did not close the window");

   chk_off_no_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_q.phase == PH_OFF) |=> !s_q.sys_reset)
      else $error("system reset raised while the watchdog was off");
endmodule // watchdog_control_status

// *** tb/tb.sv ***
/* Self-checking bench of the watchdog control and status block.
   Assumes the design package and an APB slave with zero wait states. */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import wdt_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 4'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, watchdog_enabled, system_reset, err;
   logic osc_pin = 1'b0, unlock_key = 1'b0, restart_instr = 1'b0, debug_mode = 1'b0, boot_done = 1'b0;
   logic [7:0] boot_config = 8'h00;
   logic [1:0] osc_div = 2'h0;
   int n_errors = 0, samples_checked = 0, cycles = 0;

   watchdog_control_status dut_u (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .osc_pin, .unlock_key, .restart_instr, .debug_mode, .boot_done, .boot_config,
      .watchdog_enabled, .system_reset);

   always #10 ref_clk = ~ref_clk;

   // The oscillator runs at an eighth of ref_clk so that timeouts stay short.
   always @(posedge ref_clk) begin
      osc_div <= osc_div + 2'h1;
      if (osc_div == 2'h3) osc_pin <= ~osc_pin;
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         close_out();
      end
   end

   task automatic close_out();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input string what, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check(what, rd, {24'h0, exp});
   endtask

   // Writes through the timed-write unlock, as protected bits demand.
   task automatic pwr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      unlock_key <= 1'b1;
      @(posedge ref_clk);
      unlock_key <= 1'b0;
      apb(1'b1, a, d);
   endtask

   // Polls until the control value has crossed, so no write overlaps it.
   task automatic wait_sync();
      rd = 32'h1;
      while (rd[SYNC_PENDING_BIT] !== 1'b0) apb(1'b0, ADDR_STATUS, 8'h00);
   endtask

   task automatic restart();
      restart_instr <= 1'b1;
      @(posedge ref_clk);
      restart_instr <= 1'b0;
   endtask

   task automatic wait_rst(input int lim, output int n);
      n = 0;
      while (system_reset !== 1'b1 && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
   endtask

   task automatic t_reset();
      rd_chk(ADDR_CONTROL, "control reset", CONTROL_RESET);
      rd_chk(ADDR_STATUS, "status reset", STATUS_RESET);
      check("enabled at reset", {31'h0, watchdog_enabled}, 32'h0);
      apb(1'b0, 4'h8, 8'h00);
      check("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b1, ADDR_CONTROL, 8'h01);
      rd_chk(ADDR_CONTROL, "unprotected control", 8'h00);
      apb(1'b1, ADDR_STATUS, 8'h80);
      rd_chk(ADDR_STATUS, "unprotected lock", 8'h00);
   endtask

   task automatic t_timeout();
      int n;
      pwr(ADDR_CONTROL, 8'h01);
      rd_chk(ADDR_STATUS, "sync pending set", 8'h01);
      check("not yet applied", {31'h0, watchdog_enabled}, 32'h0);
      wait_sync();
      check("enabled", {31'h0, watchdog_enabled}, 32'h1);
      rd_chk(ADDR_CONTROL, "control value", 8'h01);
      wait_rst(200, n);
      check("first timeout", {31'h0, n >= 40 && n <= 100}, 32'h1);
      @(posedge ref_clk);
      wait_rst(200, n);
      check("rearmed timeout", {31'h0, n >= 56 && n <= 72}, 32'h1);
   endtask

   task automatic t_restart();
      int n;
      int hits;
      hits = 0;
      pwr(ADDR_CONTROL, 8'h02);
      wait_sync();
      restart();
      repeat (40) @(posedge ref_clk);
      for (int i = 0; i < 320; i++) begin
         restart_instr <= (i % 32 == 0);
         @(posedge ref_clk);
         if (system_reset === 1'b1) hits++;
      end
      restart_instr <= 1'b0;
      check("no reset while served", hits, 32'h0);
      wait_rst(200, n);
      check("reset after restarts stop", {31'h0, n >= 90 && n <= 140}, 32'h1);
   endtask

   task automatic t_window();
      int n;
      restart();
      pwr(ADDR_CONTROL, 8'h22);
      wait_sync();
      restart();
      repeat (40) @(posedge ref_clk);
      restart();
      wait_rst(60, n);
      check("restart in closed window", {31'h0, n < 60}, 32'h1);
   endtask

   task automatic t_lock();
      pwr(ADDR_STATUS, 8'h01);
      rd_chk(ADDR_STATUS, "sync pending read only", 8'h00);
      pwr(ADDR_STATUS, 8'h80);
      rd_chk(ADDR_STATUS, "lock set", 8'h80);
      pwr(ADDR_CONTROL, 8'h05);
      rd_chk(ADDR_CONTROL, "locked control", 8'h22);
      pwr(ADDR_STATUS, 8'h00);
      rd_chk(ADDR_STATUS, "lock kept", 8'h80);
      debug_mode <= 1'b1;
      pwr(ADDR_STATUS, 8'h00);
      rd_chk(ADDR_STATUS, "lock cleared in debug", 8'h00);
      debug_mode <= 1'b0;
      boot_done <= 1'b1;
      @(posedge ref_clk);
      boot_done <= 1'b0;
      @(posedge ref_clk);
      rd_chk(ADDR_STATUS, "automatic lock", 8'h80);
   endtask

   // Resets again in mid-run with a non-zero strap, which must load at reset release and lock at boot end.
   task automatic t_boot();
      boot_config <= 8'h03;
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd_chk(ADDR_CONTROL, "strap loaded", 8'h03);
      check("strap enables", {31'h0, watchdog_enabled}, 32'h1);
      rd_chk(ADDR_STATUS, "no lock before boot end", 8'h00);
      boot_done <= 1'b1;
      @(posedge ref_clk);
      boot_done <= 1'b0;
      @(posedge ref_clk);
      rd_chk(ADDR_STATUS, "strap lock", 8'h80);
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_reset();
      t_timeout();
      t_restart();
      t_window();
      t_lock();
      t_boot();
      close_out();
   end
endmodule // tb
